//--- rtl/sfc_host.sv
// Host controller that frames, admits and decodes commands for a serial flash.
`timescale 1ns/1ps
`include "sfc_cfg.svh"

// Notes on behaviour
// - Identification read sends its opcode, then reads.
// - Stop drops chip select in the data or identification phase, even mid byte; it is ignored during the header.
// - Continuation codes prefix the manufacturer code.
// - Groups A and C classified by opcode.
// - Groups B and D classified by opcode.
// - No command while group A runs.
// - Only group C during group B busy.
// - Group C uses the other buffer or none.
// - Only status read during group D busy.
// - Array read opcodes recognised.
// - Buffer read opcodes recognised.
// - Buffer write and erase-program opcodes recognised.
// - Program without erase and through-buffer opcodes.
// - Protection commands use a four-byte sequence.
// - Register read opcodes recognised.
// - Security program sends three zero bytes.
module sfc_host #(
  parameter int unsigned SCK_HALF = 4,
  parameter int unsigned MAX_CONT = 8
) (
  input wire logic CLK, // System clock, 10 MHz.
  input wire logic RESETN, // Synchronous reset, active low.
  input wire logic CMD_VALID, // Command request.
  output logic CMD_READY, // Controller can take a command.
  input wire logic [7:0] CMD_OP, // Opcode, or selector when CMD_PROT is set.
  input wire logic CMD_PROT, // Send the protection prefix before CMD_OP.
  input wire logic [23:0] CMD_ADDR, // Address bytes of the header.
  output logic CMD_ERR, // Pulse: command refused.
  input wire logic CMD_STOP, // End the open frame in the data or identification phase.
  input wire logic DATA_VALID, // Data phase byte offered.
  output logic DATA_READY, // Data phase byte taken.
  input wire logic [7:0] DATA_TX, // Data phase byte to send.
  output logic RD_VALID, // Pulse: RD_DATA is new.
  output logic [7:0] RD_DATA, // Byte read in the data phase.
  output logic ID_DONE, // Pulse: identification fields are new.
  output logic ID_BAD, // Identification layout unexpected.
  output logic [7:0] ID_MFR, // Manufacturer code.
  output logic [2:0] ID_FAMILY, // Family code.
  output logic [4:0] ID_DENSITY, // Density code.
  output logic [2:0] ID_CELL_TECH_CODE, // Cell technology code.
  output logic [4:0] ID_VERSION, // Product version code.
  output logic [7:0] ID_EXT_LEN, // Extended information length.
  output logic DEV_BUSY, // Device in a self-timed phase.
  output logic SPI_CS_N, // Chip select, active low.
  output logic SPI_SCK, // Serial clock.
  output logic SPI_MOSI, // Serial data to the device.
  input wire logic SPI_MISO // Serial data from the device.
);

  // ----------------------------------------
  // Opcode classification.
  // ----------------------------------------
  function automatic sfc_pkg::sfc_dec_t decode(input logic [7:0] op, input logic prot);
    sfc_pkg::sfc_dec_t d;
    d = '{ok: 1'b1, grp: sfc_pkg::GRP_A, nhdr: `SFC_HDR_FULL, bufsel: `SFC_BUF_NONE};
    if (prot) begin
      case (op)
        `SFC_SEL_EN, `SFC_SEL_DIS: d.grp = sfc_pkg::GRP_P;
        `SFC_SEL_ERASE, `SFC_SEL_PGM, `SFC_SEL_LOCK: d.grp = sfc_pkg::GRP_D;
        default: d.ok = 1'b0;
      endcase
    end else begin
      case (op)
        `SFC_OP_PAGE_RD, `SFC_OP_CAR_LEG, `SFC_OP_CAR_LF, `SFC_OP_CAR_HF,
        `SFC_OP_PROT_RD, `SFC_OP_LOCK_RD, `SFC_OP_SEC_RD: d.grp = sfc_pkg::GRP_A;
        `SFC_OP_BUF1_RD_LF, `SFC_OP_BUF1_RD, `SFC_OP_BUF1_WR: begin
          d.grp = sfc_pkg::GRP_C;
          d.bufsel = `SFC_BUF_1;
        end
        `SFC_OP_BUF2_RD_LF, `SFC_OP_BUF2_RD, `SFC_OP_BUF2_WR: begin
          d.grp = sfc_pkg::GRP_C;
          d.bufsel = `SFC_BUF_2;
        end
        // status and identification in group C
        `SFC_OP_STATUS, `SFC_OP_ID: begin
          d.grp = sfc_pkg::GRP_C;
          d.nhdr = `SFC_HDR_ONE;
        end
        // buffer programs, through buffer, transfers, compares and rewrites in group B
        `SFC_OP_B1_PGM_ER, `SFC_OP_B1_PGM, `SFC_OP_THRU1, `SFC_OP_XFER1, `SFC_OP_CMP1,
        `SFC_OP_REWR1: begin
          d.grp = sfc_pkg::GRP_B;
          d.bufsel = `SFC_BUF_1;
        end
        `SFC_OP_B2_PGM_ER, `SFC_OP_B2_PGM, `SFC_OP_THRU2, `SFC_OP_XFER2, `SFC_OP_CMP2,
        `SFC_OP_REWR2: begin
          d.grp = sfc_pkg::GRP_B;
          d.bufsel = `SFC_BUF_2;
        end
        // erases in group B, security program in D
        `SFC_OP_PAGE_ER, `SFC_OP_BLOCK_ER, `SFC_OP_SECT_ER: d.grp = sfc_pkg::GRP_B;
        `SFC_OP_SEC_PGM: d.grp = sfc_pkg::GRP_D;
        default: d.ok = 1'b0;
      endcase
    end
    return d;
  endfunction

  // Header byte at a given position of the frame.
  function automatic logic [7:0] hdr_byte(input logic [2:0] i, input logic [7:0] op,
                                          input logic [23:0] addr, input logic prot);
    logic [7:0] b;
    b = op;
    if (prot) begin
      case (i)
        3'h0: b = `SFC_PRE0;
        3'h1: b = `SFC_PRE1;
        3'h2: b = `SFC_PRE2;
        default: b = op;
      endcase
    end else if (i != 3'h0) begin
      if (op == `SFC_OP_SEC_PGM) begin
        b = `SFC_ZERO;
      end else begin
        case (i)
          3'h1: b = addr[23:16];
          3'h2: b = addr[15:8];
          default: b = addr[7:0];
        endcase
      end
    end
    return b;
  endfunction

  sfc_pkg::sfc_st_reg_t q, n;
  sfc_pkg::sfc_dec_t dec_in;
  logic allow, accept, sh_start, sh_abort, sh_busy, sh_done;
  logic [7:0] sh_tx, sh_rx;

  // ----------------------------------------
  // Admission of a new command.
  // ----------------------------------------
  // A self-timed group B phase admits only group C on the other buffer or on none; group D admits
  // only the status read. The frame of a group A command is closed before any other.
  always_comb begin
    dec_in = decode(CMD_OP, CMD_PROT);
    // group C during group B busy
    // status read during group D busy
    case (q.busy_grp)
      sfc_pkg::GRP_NONE: allow = dec_in.ok;
      sfc_pkg::GRP_B: allow = dec_in.ok && dec_in.grp == sfc_pkg::GRP_C &&
                              (dec_in.bufsel == `SFC_BUF_NONE || dec_in.bufsel != q.busy_buf);
      sfc_pkg::GRP_D: allow = !CMD_PROT && CMD_OP == `SFC_OP_STATUS;
      default: allow = 1'b0;
    endcase
  end

  assign CMD_READY = (q.st == sfc_pkg::ST_IDLE);
  assign accept = CMD_VALID && CMD_READY && allow;
  assign DATA_READY = (q.st == sfc_pkg::ST_DATA) && !sh_busy && !sh_done && !CMD_STOP;

  // ----------------------------------------
  // Frame sequencer.
  // ----------------------------------------
  always_comb begin
    n = q;
    n.id_done = 1'b0;
    n.err = 1'b0;
    n.rd_valid = 1'b0;
    sh_start = 1'b0;
    sh_abort = 1'b0;
    sh_tx = hdr_byte(q.idx + 3'h1, q.op, q.addr, q.prot);
    case (q.st)
      sfc_pkg::ST_IDLE: begin
        sh_tx = hdr_byte(3'h0, CMD_OP, CMD_ADDR, CMD_PROT);
        if (accept) begin
          n.cs_n = 1'b0;
          n.st = sfc_pkg::ST_HDR;
          n.idx = 3'h0;
          n.dec = dec_in;
          n.op = CMD_OP;
          n.addr = CMD_ADDR;
          n.prot = CMD_PROT;
          sh_start = 1'b1;
        end else if (CMD_VALID) begin
          n.err = 1'b1;
        end
      end
      sfc_pkg::ST_HDR: begin
        if (sh_done) begin
          if (q.idx + 3'h1 < q.dec.nhdr) begin
            n.idx = q.idx + 3'h1;
            sh_start = 1'b1;
          end else if (!q.prot && q.op == `SFC_OP_ID) begin
            n.st = sfc_pkg::ST_ID;
            n.idph = 2'h0;
            n.cont = 4'h0;
            sh_tx = `SFC_ZERO;
            sh_start = 1'b1;
          end else begin
            n.st = sfc_pkg::ST_DATA;
          end
        end
      end
      sfc_pkg::ST_DATA: begin
        sh_tx = DATA_TX;
        if (CMD_STOP) begin
          sh_abort = 1'b1;
          n.cs_n = 1'b1;
          n.st = sfc_pkg::ST_END;
        end else if (sh_done) begin
          n.rd_data = sh_rx;
          n.rd_valid = 1'b1;
          if (!q.prot && q.op == `SFC_OP_STATUS && sh_rx[`SFC_RDY_BIT]) begin
            n.busy_grp = sfc_pkg::GRP_NONE;
          end
        end else if (DATA_READY && DATA_VALID) begin
          sh_start = 1'b1;
        end
      end
      sfc_pkg::ST_ID: begin
        sh_tx = `SFC_ZERO;
        if (CMD_STOP) begin
          sh_abort = 1'b1;
          n.cs_n = 1'b1;
          n.st = sfc_pkg::ST_END;
        end else if (sh_done) begin
          sh_start = 1'b1;
          case (q.idph)
            2'h0: begin
              if (sh_rx == `SFC_CONT_CODE) begin
                n.cont = q.cont + 4'h1;
                // A device that never stops prefixing is given up on after MAX_CONT bytes.
                if (q.cont == 4'(MAX_CONT - 1)) begin
                  sh_start = 1'b0;
                  n.id_done = 1'b1;
                  n.id_bad = 1'b1;
                  n.cs_n = 1'b1;
                  n.st = sfc_pkg::ST_END;
                end
              end else begin
                n.mfr = sh_rx;
                n.idph = 2'h1;
              end
            end
            2'h1: begin
              n.dev1 = sh_rx;
              n.idph = 2'h2;
            end
            2'h2: begin
              n.dev2 = sh_rx;
              n.idph = 2'h3;
            end
            default: begin
              sh_start = 1'b0;
              n.ext = sh_rx;
              n.id_done = 1'b1;
              n.id_bad = (q.cont != 4'h0) || (sh_rx != `SFC_ZERO);
              n.cs_n = 1'b1;
              n.st = sfc_pkg::ST_END;
            end
          endcase
        end
      end
      sfc_pkg::ST_END: begin
        // Busy is set only after the frame closes, since the timed phase starts there.
        n.cs_n = 1'b1;
        if (q.dec.grp == sfc_pkg::GRP_B || q.dec.grp == sfc_pkg::GRP_D) begin
          n.busy_grp = q.dec.grp;
          n.busy_buf = q.dec.bufsel;
        end
        n.st = sfc_pkg::ST_IDLE;
      end
      default: n.st = sfc_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register.
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      q <= '0;
      q.cs_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  sfc_shift #(.SCK_HALF(SCK_HALF)) u_shift (
    .clk(CLK),
    .resetn(RESETN),
    .start(sh_start),
    .abort(sh_abort),
    .tx_in(sh_tx),
    .miso(SPI_MISO),
    .sck(SPI_SCK),
    .mosi(SPI_MOSI),
    .busy(sh_busy),
    .done(sh_done),
    .rx(sh_rx)
  );

  assign ID_FAMILY = q.dev1[`SFC_HI3_MSB:`SFC_HI3_LSB];
  assign ID_DENSITY = q.dev1[`SFC_LO5_MSB:0];
  assign ID_CELL_TECH_CODE = q.dev2[`SFC_HI3_MSB:`SFC_HI3_LSB];
  assign ID_VERSION = q.dev2[`SFC_LO5_MSB:0];
  assign ID_MFR = q.mfr;
  assign ID_EXT_LEN = q.ext;
  assign ID_DONE = q.id_done;
  assign ID_BAD = q.id_bad;
  assign CMD_ERR = q.err;
  assign RD_DATA = q.rd_data;
  assign RD_VALID = q.rd_valid;
  assign DEV_BUSY = (q.busy_grp != sfc_pkg::GRP_NONE);
  assign SPI_CS_N = q.cs_n;

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  AST_ID_OPCODE: assert property (accept && !CMD_PROT && CMD_OP == `SFC_OP_ID |->
    sh_start && sh_tx == `SFC_OP_ID ##1 !SPI_CS_N) else $error("identification opcode not sent");
  AST_STOP_CS: assert property ((q.st == sfc_pkg::ST_DATA || q.st == sfc_pkg::ST_ID) && CMD_STOP |=>
    SPI_CS_N && !SPI_SCK ##1 CMD_READY) else $error("stop did not close the frame");
  AST_EXT_LEN: assert property (ID_DONE && ID_EXT_LEN != `SFC_ZERO |-> ID_BAD)
    else $error("nonzero length not flagged");
  AST_FAMILY: assert property (q.st == sfc_pkg::ST_ID && q.idph == 2'h1 && sh_done && !CMD_STOP |=>
    ID_FAMILY == $past(sh_rx[7:5]) && ID_DENSITY == $past(sh_rx[4:0])) else $error("device byte one split wrong");
  AST_CELL: assert property (q.st == sfc_pkg::ST_ID && q.idph == 2'h2 && sh_done && !CMD_STOP |=>
    ID_CELL_TECH_CODE == $past(sh_rx[7:5]) && ID_VERSION == $past(sh_rx[4:0])) else $error("device byte two split wrong");
  AST_CONT: assert property (q.st == sfc_pkg::ST_ID && q.idph == 2'h0 && sh_done && !CMD_STOP &&
    sh_rx != `SFC_CONT_CODE |=> ID_MFR == $past(sh_rx) && q.idph == 2'h1) else $error("manufacturer byte not kept");
  AST_SINGLE_MFR: assert property (ID_DONE && q.cont != 4'h0 |-> ID_BAD)
    else $error("prefixed manufacturer code not flagged");
  AST_GROUP_A: assert property (accept && !CMD_PROT && CMD_OP == `SFC_OP_PAGE_RD |=>
    q.dec.grp == sfc_pkg::GRP_A ##1 !CMD_READY) else $error("page read not in group A");
  AST_ONE_FRAME: assert property (!SPI_CS_N |-> !CMD_READY)
    else $error("command admitted during an open frame");
  AST_B_ONLY_C: assert property (accept && q.busy_grp == sfc_pkg::GRP_B |->
    dec_in.grp == sfc_pkg::GRP_C && (dec_in.bufsel == `SFC_BUF_NONE || dec_in.bufsel != q.busy_buf))
    else $error("wrong command during group B");
  AST_D_STATUS: assert property (accept && q.busy_grp == sfc_pkg::GRP_D |->
    CMD_OP == `SFC_OP_STATUS && !CMD_PROT) else $error("command other than status during group D");
  AST_PROT_SEQ: assert property (q.st == sfc_pkg::ST_HDR && q.prot && sh_start |->
    sh_tx == (q.idx == 3'h0 ? `SFC_PRE1 : q.idx == 3'h1 ? `SFC_PRE2 : q.op)) else $error("protection prefix wrong");
  AST_SEC_ZERO: assert property (q.st == sfc_pkg::ST_HDR && !q.prot && q.op == `SFC_OP_SEC_PGM && sh_start |->
    sh_tx == `SFC_ZERO) else $error("security program byte not zero");
  AST_BAD_OP: assert property (CMD_VALID && CMD_READY && !allow |=>
    CMD_ERR && SPI_CS_N && q.st == sfc_pkg::ST_IDLE) else $error("refused command changed state");

  COV_ID: cover property (ID_DONE && !ID_BAD);
  COV_STATUS_CLEAR: cover property (DEV_BUSY ##1 !DEV_BUSY);
  COV_REFUSE: cover property (CMD_ERR && DEV_BUSY);

endmodule

//--- rtl/sfc_shift.sv
// Mode 0 byte shifter with serial clock divider and filtered data input.
`timescale 1ns/1ps
`include "sfc_cfg.svh"

module sfc_shift #(
  parameter int unsigned SCK_HALF = 4
) (
  input wire logic clk, // System clock.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic start, // Load a byte and shift it.
  input wire logic abort, // Drop the byte in flight.
  input wire logic [7:0] tx_in, // Byte to send.
  input wire logic miso, // Serial data from the device.
  output logic sck, // Serial clock.
  output logic mosi, // Serial data to the device.
  output logic busy, // Byte in flight.
  output logic done, // One-cycle pulse at byte end.
  output logic [7:0] rx // Byte received.
);

  sfc_pkg::sfc_sh_t q, n;
  logic tick;

  // ----------------------------------------
  // Next state.
  // ----------------------------------------
  // The input crosses from the pin through three flops; a new level is taken only
  // once the last two agree, so a glitch shorter than a cycle never reaches rx.
  always_comb begin
    n = q;
    n.done = 1'b0;
    n.sync = {q.sync[1:0], miso};
    if (q.sync[1] == q.sync[2]) begin
      n.filt = q.sync[2];
    end
    tick = (q.div == 8'(SCK_HALF - 1));
    if (abort) begin
      n.busy = 1'b0;
      n.sck = 1'b0;
    end else if (start) begin
      n.tx = tx_in;
      n.busy = 1'b1;
      n.sck = 1'b0;
      n.bitn = 3'h0;
      n.div = 8'h00;
    end else if (q.busy) begin
      if (tick) begin
        n.div = 8'h00;
        if (!q.sck) begin
          n.sck = 1'b1;
        end else begin
          // Sampling at the end of the high phase leaves a full period for the sync delay.
          n.sck = 1'b0;
          n.rx = {q.rx[6:0], q.filt};
          if (q.bitn == 3'h7) begin
            n.busy = 1'b0;
            n.done = 1'b1;
          end else begin
            n.bitn = q.bitn + 3'h1;
            n.tx = {q.tx[6:0], 1'b0};
          end
        end
      end else begin
        n.div = q.div + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // State register.
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign sck = q.sck;
  assign mosi = q.tx[7];
  assign busy = q.busy;
  assign done = q.done;
  assign rx = q.rx;

endmodule

//--- shared/sfc_cfg.svh
// Constants of the serial flash command host: opcodes, field positions and header lengths.
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

// ----------------------------------------
// Read opcodes.
// ----------------------------------------
`define SFC_OP_PAGE_RD 8'hD2
`define SFC_OP_CAR_LEG 8'hE8
`define SFC_OP_CAR_LF 8'h03
`define SFC_OP_CAR_HF 8'h0B
`define SFC_OP_BUF1_RD_LF 8'hD1
`define SFC_OP_BUF2_RD_LF 8'hD3
`define SFC_OP_BUF1_RD 8'hD4
`define SFC_OP_BUF2_RD 8'hD6

// ----------------------------------------
// Program, erase and transfer opcodes.
// ----------------------------------------
`define SFC_OP_BUF1_WR 8'h84
`define SFC_OP_BUF2_WR 8'h87
`define SFC_OP_B1_PGM_ER 8'h83
`define SFC_OP_B2_PGM_ER 8'h86
`define SFC_OP_B1_PGM 8'h88
`define SFC_OP_B2_PGM 8'h89
`define SFC_OP_THRU1 8'h82
`define SFC_OP_THRU2 8'h85
`define SFC_OP_PAGE_ER 8'h81
`define SFC_OP_BLOCK_ER 8'h50
`define SFC_OP_SECT_ER 8'h7C
`define SFC_OP_XFER1 8'h53
`define SFC_OP_XFER2 8'h55
`define SFC_OP_CMP1 8'h60
`define SFC_OP_CMP2 8'h61
`define SFC_OP_REWR1 8'h58
`define SFC_OP_REWR2 8'h59

// ----------------------------------------
// Register, status and identification opcodes.
// ----------------------------------------
`define SFC_OP_STATUS 8'hD7
`define SFC_OP_ID 8'h9F
`define SFC_OP_PROT_RD 8'h32
`define SFC_OP_LOCK_RD 8'h35
`define SFC_OP_SEC_RD 8'h77
`define SFC_OP_SEC_PGM 8'h9B
`define SFC_PRE0 8'h3D
`define SFC_PRE1 8'h2A
`define SFC_PRE2 8'h7F
`define SFC_SEL_EN 8'hA9
`define SFC_SEL_DIS 8'h9A
`define SFC_SEL_ERASE 8'hCF
`define SFC_SEL_PGM 8'hFC
`define SFC_SEL_LOCK 8'h30
`define SFC_CONT_CODE 8'h7F
`define SFC_ZERO 8'h00

// ----------------------------------------
// Field positions and counts.
// ----------------------------------------
`define SFC_RDY_BIT 7
`define SFC_HI3_MSB 7
`define SFC_HI3_LSB 5
`define SFC_LO5_MSB 4
`define SFC_HDR_FULL 3'h4
`define SFC_HDR_ONE 3'h1
`define SFC_BUF_NONE 2'h0
`define SFC_BUF_1 2'h1
`define SFC_BUF_2 2'h2

`endif

//--- shared/sfc_pkg.sv
// Types shared by the serial flash command host and its byte shifter.
package sfc_pkg;

  // ----------------------------------------
  // Command groups and controller states.
  // ----------------------------------------
  typedef enum logic [2:0] {GRP_NONE, GRP_A, GRP_B, GRP_C, GRP_D, GRP_P} sfc_grp_t;
  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_DATA, ST_ID, ST_END} sfc_st_t;

  typedef struct packed {
    logic ok;
    sfc_grp_t grp;
    logic [2:0] nhdr;
    logic [1:0] bufsel;
  } sfc_dec_t;

  // ----------------------------------------
  // Register images of both modules.
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] tx;
    logic [7:0] rx;
    logic [2:0] bitn;
    logic busy;
    logic sck;
    logic done;
    logic [2:0] sync;
    logic filt;
    logic [7:0] div;
  } sfc_sh_t;

  typedef struct packed {
    sfc_st_t st;
    logic cs_n;
    logic [2:0] idx;
    sfc_dec_t dec;
    logic [7:0] op;
    logic [23:0] addr;
    logic prot;
    sfc_grp_t busy_grp;
    logic [1:0] busy_buf;
    logic [1:0] idph;
    logic [3:0] cont;
    logic [7:0] mfr;
    logic [7:0] dev1;
    logic [7:0] dev2;
    logic [7:0] ext;
    logic id_done;
    logic id_bad;
    logic err;
    logic [7:0] rd_data;
    logic rd_valid;
  } sfc_st_reg_t;

endpackage

//--- verification/sfc_dev_model.sv
// Behavioural serial flash device answering identification and status reads.
`timescale 1ns/1ps

module sfc_dev_model #(
  parameter logic [7:0] MFR = 8'h5A, // Arbitrary maker code.
  parameter logic [7:0] DEV1 = 8'hC9, // Arbitrary family and density code.
  parameter logic [7:0] DEV2 = 8'h6B, // Arbitrary cell technology and version code.
  parameter logic [7:0] STAT = 8'h9C // Status byte with the ready bit set.
) (
  input wire logic cs_n, // Chip select, active low.
  input wire logic sck, // Serial clock.
  input wire logic mosi, // Data from the host.
  output logic miso // Data to the host.
);
  // ----------
  // Frame decoding and response.
  // ----------
  logic [7:0] op = 8'h00;
  logic [39:0] sh = 40'h00_0000_0000;
  logic act = 1'b0;
  // The bench sets these to make the answer deviate from the single-byte layout.
  logic pre = 1'b0; // Send one continuation byte before the maker code.
  logic [7:0] ext = 8'h00; // Length byte of the identification answer.
  int n = 0;

  initial miso = 1'b0;

  // A new frame starts with an empty opcode count.
  always @(negedge cs_n) begin
    n = 0;
    act = 1'b0;
  end

  // float on release
  // The line has no pull, so a released output shows the inverse of its last level.
  always @(posedge cs_n) miso = ~miso;

  always @(posedge sck) if (!cs_n) begin
    op = {op[6:0], mosi};
    n = n + 1;
  end

  // response order
  // Data moves after the falling edge, so it is steady through the whole next bit.
  always @(negedge sck) if (!cs_n) begin
    if (n == 8 && op == 8'h9F) begin
      act = 1'b1;
      sh = pre ? {8'h7F, MFR, DEV1, DEV2, ext} : {MFR, DEV1, DEV2, ext, 8'h00};
    end else if (n == 8 && op == 8'hD7) begin
      act = 1'b1;
      sh = {STAT, STAT, STAT, STAT, STAT};
    end
    if (act) begin
      miso = sh[39];
      sh = {sh[38:0], sh[39]};
    end else begin
      miso = ~miso;
    end
  end
endmodule

//--- verification/sfc_tb.sv
// Self-checking bench for the serial flash command host.
`timescale 1ns/1ps

module testbench;
  // ----------
  // Signals, design and device.
  // ----------
  logic CLK = 0, RESETN = 0, CMD_VALID = 0, CMD_PROT = 0, CMD_STOP = 0, DATA_VALID = 0;
  logic CMD_READY, CMD_ERR, DATA_READY, RD_VALID, ID_DONE, ID_BAD, DEV_BUSY, SPI_CS_N, SPI_SCK, SPI_MOSI, SPI_MISO;
  logic [7:0] CMD_OP = 8'h00, DATA_TX = 8'h00, RD_DATA, ID_MFR, ID_EXT_LEN;
  logic [23:0] CMD_ADDR = 24'h12_3456;
  logic [2:0] ID_FAMILY, ID_CELL_TECH_CODE;
  logic [4:0] ID_DENSITY, ID_VERSION;
  logic [31:0] hdr = 32'h0000_0000;
  int n_errors = 0, comparisons = 0;
  logic [7:0] ok_ops [13] = '{8'hD2, 8'hE8, 8'h03, 8'h0B, 8'h32, 8'h35, 8'h77, 8'hD1, 8'hD3, 8'hD4, 8'hD6, 8'h84, 8'h87};
  logic [7:0] b_ops [15] = '{8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85, 8'h81, 8'h50, 8'h7C, 8'h53, 8'h55, 8'h60,
    8'h61, 8'h58, 8'h59};
  logic [7:0] d_ops [4] = '{8'hCF, 8'hFC, 8'h30, 8'h9B};

  sfc_host #(.SCK_HALF(4), .MAX_CONT(8)) dut (.CLK, .RESETN, .CMD_VALID, .CMD_READY, .CMD_OP, .CMD_PROT, .CMD_ADDR,
    .CMD_ERR, .CMD_STOP, .DATA_VALID, .DATA_READY, .DATA_TX, .RD_VALID, .RD_DATA, .ID_DONE, .ID_BAD, .ID_MFR,
    .ID_FAMILY, .ID_DENSITY, .ID_CELL_TECH_CODE, .ID_VERSION, .ID_EXT_LEN, .DEV_BUSY, .SPI_CS_N, .SPI_SCK,
    .SPI_MOSI, .SPI_MISO);
  sfc_dev_model dev (.cs_n(SPI_CS_N), .sck(SPI_SCK), .mosi(SPI_MOSI), .miso(SPI_MISO));

  // Clock of 100 ns period.
  always #50 CLK = ~CLK;

  // Header bits are taken on the rising serial clock, where the device samples them.
  always @(posedge SPI_SCK) hdr <= {hdr[30:0], SPI_MOSI};

  // ----------
  // Shared tasks.
  // ----------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic report_and_stop;
    $display("Errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Request one command; an admitted one other than identification is followed through its header.
  task automatic cmd(input logic [7:0] op, input logic pr, input logic ok);
    logic [31:0] e;
    @(negedge CLK);
    repeat (8) if (!CMD_READY) @(negedge CLK);
    hdr = 32'h0000_0000;
    CMD_OP = op;
    CMD_PROT = pr;
    CMD_VALID = 1;
    @(negedge CLK);
    CMD_VALID = 0;
    chk({CMD_ERR, SPI_CS_N}, ok ? 2'b00 : 2'b11);
    if (ok && op != 8'h9F) begin
      repeat (400) if (!DATA_READY) @(negedge CLK);
      e = op == 8'hD7 ? {24'h00_0000, op} : {op, CMD_ADDR};
      if (pr) e = {24'h3D_2A7F, op};
      if (op == 8'h9B) e[23:0] = 24'h00_0000;
      chk(hdr, e);
    end
  endtask

  // Close the open frame; the byte in flight is dropped.
  task automatic stop;
    @(negedge CLK);
    CMD_STOP = 1;
    @(negedge CLK);
    CMD_STOP = 0;
    chk({SPI_CS_N, SPI_SCK}, 2'b10);
    repeat (4) if (!CMD_READY) @(negedge CLK);
  endtask

  // A status read with the ready bit set ends the self-timed phase.
  task automatic status;
    cmd(8'hD7, 0, 1);
    DATA_VALID = 1;
    @(negedge CLK);
    DATA_VALID = 0;
    repeat (80) if (!RD_VALID) @(negedge CLK);
    chk({RD_VALID, RD_DATA}, {1'b1, dev.STAT});
    stop;
    chk(DEV_BUSY, 1'b0);
  endtask

  // ----------
  // Scenarios and watchdog.
  // ----------
  initial begin
    repeat (5) @(negedge CLK);
    RESETN = 1;
    chk({SPI_CS_N, SPI_SCK, CMD_READY, DEV_BUSY, CMD_ERR}, 5'b10100);
    cmd(8'h9F, 0, 1);
    repeat (600) if (!ID_DONE) @(negedge CLK);
    chk({ID_DONE, ID_BAD, ID_MFR}, {2'b10, dev.MFR});
    chk({ID_FAMILY, ID_DENSITY, ID_CELL_TECH_CODE, ID_VERSION}, {dev.DEV1, dev.DEV2});
    chk(ID_EXT_LEN, 8'h00);
    // A prefixed maker code is skipped but flagged as unexpected.
    dev.pre = 1'b1;
    cmd(8'h9F, 0, 1);
    repeat (600) if (!ID_DONE) @(negedge CLK);
    chk({ID_DONE, ID_BAD, ID_MFR, ID_EXT_LEN}, {2'b11, dev.MFR, 8'h00});
    // A nonzero length byte is flagged as unexpected.
    dev.pre = 1'b0;
    dev.ext = 8'h01;
    cmd(8'h9F, 0, 1);
    repeat (600) if (!ID_DONE) @(negedge CLK);
    chk({ID_DONE, ID_BAD, ID_EXT_LEN}, {2'b11, 8'h01});
    dev.ext = 8'h00;
    cmd(8'h9F, 0, 1);
    repeat (100) @(negedge CLK);
    stop;
    cmd(8'hFF, 0, 0);
    cmd(8'h11, 1, 0);
    foreach (ok_ops[i]) begin
      cmd(ok_ops[i], 0, 1);
      stop;
      chk(DEV_BUSY, 1'b0);
    end
    cmd(8'hA9, 1, 1);
    stop;
    cmd(8'h9A, 1, 1);
    stop;
    chk(DEV_BUSY, 1'b0);
    foreach (b_ops[i]) begin
      cmd(b_ops[i], 0, 1);
      stop;
      chk(DEV_BUSY, 1'b1);
      cmd(8'hD2, 0, 0);
      cmd(i[0] ? 8'hD6 : 8'hD4, 0, i > 5);
      if (i > 5) stop;
      status;
    end
    foreach (d_ops[i]) begin
      cmd(d_ops[i], i < 3, 1);
      stop;
      chk(DEV_BUSY, 1'b1);
      cmd(8'hD6, 0, 0);
      status;
    end
    report_and_stop;
  end

  // A hang is cut short well beyond the expected run length.
  initial begin
    #4_000_000;
    n_errors++;
    report_and_stop;
  end
endmodule
